// *** rtl/rsif_top.sv ***
// Row-boundary strobe, interrupt and flag logic with its APB register slave.
`timescale 1ns/100ps
`include "rsif_defines.svh"

// Behaviour
// - The strobe has one period per memory row, 200 ms at 8 kHz.
// - Normal rows hold the strobe high 175 ms, then low 25 ms.
// - Cueing mode shortens the phases to 109.37 us high and 15.63 us low.
// - A fresh record start holds the strobe high one extra low-phase length.
// - The strobe pin is open drain: it only pulls low, else it releases.
// - The interrupt pin pulls low on memory full or message end until cleared.
// - Every operation ending on message end or memory full raises an interrupt.
// - The next serial transaction start clears the interrupt and releases the pin.
// - A dedicated status read reports the interrupt state instead of the pin.
// - Memory full sets when the last row ends in record or playback.
// - Message end sets only in playback on a stored marker, never in record.
// - Each row offers eight marker positions that are checked.
// - An external sample clock may replace the internal oscillator.
// - The external sample clock is divided by two at once.
module rsif_top
#(
	parameter rsif_pkg::rsif_cnt_t ROW_HIGH_TICKS = 17'(`RSIF_ROW_HIGH_TICKS),
	parameter rsif_pkg::rsif_cnt_t ROW_LOW_TICKS  = 17'(`RSIF_ROW_LOW_TICKS)
)
(
	// Clock and reset.
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire rsif_pkg::rsif_addr_t paddr,
	input  wire rsif_pkg::rsif_word_t pwdata,
	output rsif_pkg::rsif_word_t     prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Serial bus slave select pin.
	input  wire logic                ss_n,
	// External sample clock pin.
	input  wire logic                external_sample_clock,
	// Marker bits of the current row from the array.
	input  wire logic [7:0]          end_marks,
	// Current row to the array.
	output rsif_pkg::rsif_row_t      row_addr,
	// Open-drain row strobe pin.
	input  wire logic                row_boundary_strobe_i,
	output logic                     row_boundary_strobe_o,
	output logic                     row_boundary_strobe_oe,
	// Open-drain interrupt pin.
	input  wire logic                int_n_i,
	output logic                     int_n_o,
	output logic                     int_n_oe
);
	import rsif_pkg::*;

	// Pin synchronisers and edge detection.
	logic [1:0] ss_sync;
	logic       ss_last;
	logic [1:0] strobe_sync;
	logic [1:0] int_sync;
	logic [1:0] next_ss_sync;
	logic       next_ss_last;
	logic [1:0] next_strobe_sync;
	logic [1:0] next_int_sync;
	logic       ss_fall;

	// Register bus state.
	rsif_word_t next_prdata;
	logic       next_pready;
	logic       next_pslverr;
	logic       ctrl_record;
	logic       ctrl_cue;
	logic       ctrl_ext;
	rsif_row_t  start_row;
	logic       next_ctrl_record;
	logic       next_ctrl_cue;
	logic       next_ctrl_ext;
	rsif_row_t  next_start_row;
	logic       access;
	logic       done;
	logic       hit;
	logic       wr_ctrl;
	logic       go_wr;
	logic       stop_wr;
	rsif_word_t rd_mux;

	// Operation state.
	rsif_op_t   op;
	rsif_op_t   next_op;
	logic       op_record;
	logic       next_op_record;
	logic       start_pulse;
	logic       next_start_pulse;
	rsif_row_t  next_row;
	logic       full;
	logic       mark;
	logic       pend;
	logic       next_full;
	logic       next_mark;
	logic       next_pend;
	logic       set_full;
	logic       set_mark;
	logic       next_strobe_oe;

	// Timing sub-blocks.
	logic       tick;
	logic       strobe_low;
	logic       row_end;
	logic       seg_end;
	rsif_seg_t  seg_idx;

	// Tick source, internal or from the external sample clock pin.
	rsif_tick u_tick
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.ext_sel (ctrl_ext),
		.ext_clk (external_sample_clock),
		.tick    (tick)
	);

	// Row timer driving the strobe phases and the marker positions.
	rsif_row #(
		.HIGH_TICKS (ROW_HIGH_TICKS),
		.LOW_TICKS  (ROW_LOW_TICKS)
	) u_row
	(
		.clk_sys    (clk_sys),
		.rst        (rst),
		.tick       (tick),
		.start      (start_pulse),
		.active     (op == op_active),
		.record     (op_record),
		.cue        (ctrl_cue),
		.strobe_low (strobe_low),
		.row_end    (row_end),
		.seg_end    (seg_end),
		.seg_idx    (seg_idx)
	);

	// Pins from outside pass two flops; only the second one feeds logic.
	always_comb
	begin
		next_ss_sync     = {ss_sync[0], ss_n};
		next_ss_last     = ss_sync[1];
		next_strobe_sync = {strobe_sync[0], row_boundary_strobe_i};
		next_int_sync    = {int_sync[0], int_n_i};
		ss_fall          = ss_last & ~ss_sync[1];
	end

	// Registers of the synchronisers.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ss_sync     <= 2'h3;
			ss_last     <= 1'b1;
			strobe_sync <= 2'h3;
			int_sync    <= 2'h3;
		end
		else
		begin
			ss_sync     <= next_ss_sync;
			ss_last     <= next_ss_last;
			strobe_sync <= next_strobe_sync;
			int_sync    <= next_int_sync;
		end
	end

	// Read data for the addressed register.
	always_comb
	begin
		hit    = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr)
			`RSIF_CTRL_OFS:
			begin
				rd_mux[`RSIF_CTRL_GO]     = (op == op_active);
				rd_mux[`RSIF_CTRL_RECORD] = ctrl_record;
				rd_mux[`RSIF_CTRL_CUE]    = ctrl_cue;
				rd_mux[`RSIF_CTRL_EXTCLK] = ctrl_ext;
			end
			`RSIF_ROW_OFS:
			begin
				rd_mux[11:0]  = start_row;
				rd_mux[27:16] = row_addr;
			end
			`RSIF_STATUS_OFS:
			begin
				rd_mux[`RSIF_ST_FULL]       = full;
				rd_mux[`RSIF_ST_MARK]       = mark;
				rd_mux[`RSIF_ST_PEND]       = pend;
				rd_mux[`RSIF_ST_ACTIVE]     = (op == op_active);
				rd_mux[`RSIF_ST_STROBE]     = row_boundary_strobe_oe;
				rd_mux[`RSIF_ST_STROBE_PIN] = strobe_sync[1];
				rd_mux[`RSIF_ST_INT_PIN]    = int_sync[1];
			end
			`RSIF_INTSTAT_OFS:
			begin
				// Lets the host poll instead of watching the pin.
				rd_mux[`RSIF_ST_FULL] = full;
				rd_mux[`RSIF_ST_MARK] = mark;
				rd_mux[`RSIF_ST_PEND] = pend;
			end
			default:
			begin
				hit = 1'b0;
			end
		endcase
	end

	// Bus handshake: one wait state, so data is captured while the request holds.
	always_comb
	begin
		access       = psel & penable;
		done         = access & pready;
		next_pready  = access & ~pready;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (access && !pready)
		begin
			next_prdata  = pwrite ? 32'h00000000 : rd_mux;
			next_pslverr = ~hit;
		end
		wr_ctrl = done & pwrite & (paddr == `RSIF_CTRL_OFS);
		go_wr   = wr_ctrl & pwdata[`RSIF_CTRL_GO];
		stop_wr = wr_ctrl & ~pwdata[`RSIF_CTRL_GO];
	end

	// Control fields; the record choice is sampled again at each start.
	always_comb
	begin
		next_ctrl_record = ctrl_record;
		next_ctrl_cue    = ctrl_cue;
		next_ctrl_ext    = ctrl_ext;
		next_start_row   = start_row;
		if (wr_ctrl)
		begin
			next_ctrl_record = pwdata[`RSIF_CTRL_RECORD];
			next_ctrl_cue    = pwdata[`RSIF_CTRL_CUE];
			next_ctrl_ext    = pwdata[`RSIF_CTRL_EXTCLK];
		end
		if (done && pwrite && paddr == `RSIF_ROW_OFS)
			next_start_row = pwdata[11:0];
	end

	// Registers of the bus slave and control fields.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			ctrl_record <= 1'b0;
			ctrl_cue    <= 1'b0;
			ctrl_ext    <= 1'b0;
			start_row   <= `RSIF_START_ROW_RST;
		end
		else
		begin
			prdata      <= next_prdata;
			pready      <= next_pready;
			pslverr     <= next_pslverr;
			ctrl_record <= next_ctrl_record;
			ctrl_cue    <= next_ctrl_cue;
			ctrl_ext    <= next_ctrl_ext;
			start_row   <= next_start_row;
		end
	end

	// Operation sequencing and termination events.
	always_comb
	begin
		next_op          = op;
		next_row         = row_addr;
		next_op_record   = op_record;
		next_start_pulse = 1'b0;
		set_full         = 1'b0;
		set_mark         = 1'b0;
		unique case (op)
			op_idle:
			begin
				if (go_wr)
				begin
					next_op          = op_active;
					next_row         = start_row;
					next_op_record   = pwdata[`RSIF_CTRL_RECORD];
					next_start_pulse = 1'b1;
				end
			end
			op_active:
			begin
				if (stop_wr)
					next_op = op_idle;
				else if (seg_end && !op_record && end_marks[seg_idx])
				begin
					// Markers only count on playback.
					set_mark = 1'b1;
					next_op = op_idle;
				end
				else if (row_end)
				begin
					if (row_addr >= `RSIF_LAST_ROW)
					begin
						set_full = 1'b1;
						next_op  = op_idle;
					end
					else
						next_row = row_addr + 12'h001;
				end
			end
		endcase
	end

	// Sticky flags; a new event wins over a clear in the same cycle.
	always_comb
	begin
		next_full      = set_full | (full & ~ss_fall);
		next_mark      = set_mark | (mark & ~ss_fall);
		next_pend      = set_full | set_mark | (pend & ~ss_fall);
		next_strobe_oe = strobe_low & (next_op == op_active);
	end

	// Registers of the operation, flags and pins; pin data is always low.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			op                     <= op_idle;
			row_addr               <= `RSIF_START_ROW_RST;
			op_record              <= 1'b0;
			start_pulse            <= 1'b0;
			full                   <= 1'b0;
			mark                   <= 1'b0;
			pend                   <= 1'b0;
			row_boundary_strobe_o  <= 1'b0;
			row_boundary_strobe_oe <= 1'b0;
			int_n_o                <= 1'b0;
			int_n_oe               <= 1'b0;
		end
		else
		begin
			op                     <= next_op;
			row_addr               <= next_row;
			op_record              <= next_op_record;
			start_pulse            <= next_start_pulse;
			full                   <= next_full;
			mark                   <= next_mark;
			pend                   <= next_pend;
			row_boundary_strobe_o  <= 1'b0;
			row_boundary_strobe_oe <= next_strobe_oe;
			int_n_o                <= 1'b0;
			int_n_oe               <= next_pend;
		end
	end

endmodule

// *** rtl/rsif_defines.svh ***
// Offsets, field positions, reset values and timing counts of the row strobe block.
`ifndef RSIF_DEFINES_SVH
`define RSIF_DEFINES_SVH

// Register byte offsets.
`define RSIF_CTRL_OFS        8'h00
`define RSIF_ROW_OFS         8'h04
`define RSIF_STATUS_OFS      8'h08
`define RSIF_INTSTAT_OFS     8'h0C

// Control field positions.
`define RSIF_CTRL_GO         0
`define RSIF_CTRL_RECORD     1
`define RSIF_CTRL_CUE        2
`define RSIF_CTRL_EXTCLK     3

// Status field positions.
`define RSIF_ST_FULL         0
`define RSIF_ST_MARK         1
`define RSIF_ST_PEND         2
`define RSIF_ST_ACTIVE       3
`define RSIF_ST_STROBE       4
`define RSIF_ST_STROBE_PIN   5
`define RSIF_ST_INT_PIN      6

// Reset values.
`define RSIF_START_ROW_RST   12'h000

// Memory geometry.
`define RSIF_LAST_ROW        12'h95F
`define RSIF_MARKS           8

// Clock rates in kHz; the tick is the sample clock divided by two.
`define RSIF_CLK_KHZ         250000
`define RSIF_TICK_KHZ        512
`define RSIF_INT_DIV         (`RSIF_CLK_KHZ / `RSIF_TICK_KHZ)

// Row phases in microseconds, cueing phases in nanoseconds.
`define RSIF_ROW_HIGH_US     175000
`define RSIF_ROW_LOW_US      25000
`define RSIF_CUE_HIGH_NS     109370
`define RSIF_CUE_LOW_NS      15630

// Phase lengths in ticks; the cueing figures round to the nearest tick.
`define RSIF_ROW_HIGH_TICKS  (`RSIF_ROW_HIGH_US * `RSIF_TICK_KHZ / 1000)
`define RSIF_ROW_LOW_TICKS   (`RSIF_ROW_LOW_US * `RSIF_TICK_KHZ / 1000)
`define RSIF_CUE_HIGH_TICKS  ((`RSIF_CUE_HIGH_NS * `RSIF_TICK_KHZ + 500000) / 1000000)
`define RSIF_CUE_LOW_TICKS   ((`RSIF_CUE_LOW_NS * `RSIF_TICK_KHZ + 500000) / 1000000)

`endif

// *** rtl/rsif_pkg.sv ***
// Types shared by the row strobe block.
package rsif_pkg;

	typedef logic [31:0] rsif_word_t;
	typedef logic [7:0]  rsif_addr_t;
	typedef logic [16:0] rsif_cnt_t;
	typedef logic [11:0] rsif_row_t;
	typedef logic [2:0]  rsif_seg_t;

	typedef enum logic [1:0] {ph_off, ph_prime, ph_high, ph_low} rsif_phase_t;
	typedef enum logic {op_idle, op_active} rsif_op_t;

endpackage

// *** rtl/rsif_tick.sv ***
// Sample tick source: internal divider or the external clock halved.
`timescale 1ns/100ps
`include "rsif_defines.svh"

module rsif_tick
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rst,
	// Source selection and external clock pin.
	input  wire logic ext_sel,
	input  wire logic ext_clk,
	// Tick out.
	output logic      tick
);
	import rsif_pkg::*;

	localparam logic [8:0] DIV_LAST = 9'(`RSIF_INT_DIV - 1);

	logic [1:0] sync;
	logic       last;
	logic       half;
	logic [8:0] div;
	logic [1:0] next_sync;
	logic       next_last;
	logic       next_half;
	logic [8:0] next_div;
	logic       next_tick;
	logic       rise;

	// Every second rising edge gives a tick, so the pin's duty cycle never matters.
	always_comb
	begin
		next_sync = {sync[0], ext_clk};
		next_last = sync[1];
		rise      = sync[1] & ~last;
		next_half = half ^ rise;
		next_div  = (div == DIV_LAST) ? 9'h000 : div + 9'h001;
		next_tick = ext_sel ? (rise & half) : (div == DIV_LAST);
	end

	// Registers of the tick source.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sync <= 2'h0;
			last <= 1'b0;
			half <= 1'b0;
			div  <= 9'h000;
			tick <= 1'b0;
		end
		else
		begin
			sync <= next_sync;
			last <= next_last;
			half <= next_half;
			div  <= next_div;
			tick <= next_tick;
		end
	end

endmodule

// *** rtl/rsif_row.sv ***
// Row timer: strobe phases, segment boundaries and row ends.
`timescale 1ns/100ps
`include "rsif_defines.svh"

module rsif_row
#(
	parameter rsif_pkg::rsif_cnt_t HIGH_TICKS = 17'(`RSIF_ROW_HIGH_TICKS),
	parameter rsif_pkg::rsif_cnt_t LOW_TICKS  = 17'(`RSIF_ROW_LOW_TICKS)
)
(
	// Clock and reset.
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// Control.
	input  wire logic          tick,
	input  wire logic          start,
	input  wire logic          active,
	input  wire logic          record,
	input  wire logic          cue,
	// Timing out.
	output logic               strobe_low,
	output logic               row_end,
	output logic               seg_end,
	output rsif_pkg::rsif_seg_t seg_idx
);
	import rsif_pkg::*;

	localparam rsif_cnt_t CUE_HIGH = 17'(`RSIF_CUE_HIGH_TICKS);
	localparam rsif_cnt_t CUE_LOW  = 17'(`RSIF_CUE_LOW_TICKS);

	rsif_phase_t phase;
	rsif_phase_t next_phase;
	rsif_cnt_t   cnt;
	rsif_cnt_t   next_cnt;
	rsif_cnt_t   scnt;
	rsif_cnt_t   next_scnt;
	rsif_seg_t   seg;
	rsif_seg_t   next_seg;
	rsif_seg_t   next_idx;
	rsif_cnt_t   hi_n;
	rsif_cnt_t   lo_n;
	rsif_cnt_t   sg_n;
	logic        next_row_end;
	logic        next_seg_end;

	// Phase lengths follow the mode; a segment is an eighth of the row period.
	always_comb
	begin
		hi_n = cue ? CUE_HIGH : HIGH_TICKS;
		lo_n = cue ? CUE_LOW : LOW_TICKS;
		sg_n = 17'((hi_n + lo_n) >> 3);
	end

	// Phase sequencing; the row repeats until the operation stops.
	always_comb
	begin
		next_phase   = phase;
		next_cnt     = cnt;
		next_scnt    = scnt;
		next_seg     = seg;
		next_idx     = seg_idx;
		next_row_end = 1'b0;
		next_seg_end = 1'b0;
		if (!active)
		begin
			next_phase = ph_off;
			next_cnt   = 17'h00000;
			next_scnt  = 17'h00000;
			next_seg   = 3'h0;
		end
		else if (start)
		begin
			next_phase = record ? ph_prime : ph_high;
			next_cnt   = 17'h00000;
			next_scnt  = 17'h00000;
			next_seg   = 3'h0;
		end
		else if (tick)
		begin
			unique case (phase)
				ph_off:
				begin
					next_phase = ph_off;
				end
				ph_prime:
				begin
					// Strobe stays high one extra low-phase length.
					if (cnt >= lo_n - 17'h00001)
					begin
						next_phase = ph_high;
						next_cnt   = 17'h00000;
					end
					else
						next_cnt = cnt + 17'h00001;
				end
				ph_high, ph_low:
				begin
					if (scnt >= sg_n - 17'h00001)
					begin
						next_scnt    = 17'h00000;
						next_seg     = seg + 3'h1;
						next_seg_end = 1'b1;
						next_idx     = seg;
					end
					else
						next_scnt = scnt + 17'h00001;
					if (phase == ph_high && cnt >= hi_n - 17'h00001)
					begin
						next_phase = ph_low;
						next_cnt   = 17'h00000;
					end
					else if (phase == ph_low && cnt >= lo_n - 17'h00001)
					begin
						// Row end realigns segments in case the lengths do not divide by eight.
						next_phase   = ph_high;
						next_cnt     = 17'h00000;
						next_scnt    = 17'h00000;
						next_seg     = 3'h0;
						next_row_end = 1'b1;
						next_seg_end = 1'b1;
						next_idx     = seg;
					end
					else
						next_cnt = cnt + 17'h00001;
				end
			endcase
		end
	end

	// Registers of the row timer.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			phase      <= ph_off;
			cnt        <= 17'h00000;
			scnt       <= 17'h00000;
			seg        <= 3'h0;
			seg_idx    <= 3'h0;
			strobe_low <= 1'b0;
			row_end    <= 1'b0;
			seg_end    <= 1'b0;
		end
		else
		begin
			phase      <= next_phase;
			cnt        <= next_cnt;
			scnt       <= next_scnt;
			seg        <= next_seg;
			seg_idx    <= next_idx;
			strobe_low <= (next_phase == ph_low);
			row_end    <= next_row_end;
			seg_end    <= next_seg_end;
		end
	end

endmodule

// *** tb/rsif_props.sv ***
// Port checker of the row strobe block, bound into the top module.
`timescale 1ns/100ps
module rsif_props
#(
	parameter rsif_pkg::rsif_cnt_t ROW_HIGH_TICKS = 17'h0000E,
	parameter rsif_pkg::rsif_cnt_t ROW_LOW_TICKS  = 17'h00002
)
(
	// Clock and reset.
	input wire logic                clk_sys,
	input wire logic                rst,
	// Bus handshake.
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	input wire logic                pslverr,
	// Pins and array side.
	input wire logic                ss_n,
	input wire logic [7:0]          end_marks,
	input wire rsif_pkg::rsif_row_t row_addr,
	input wire logic                row_boundary_strobe_o,
	input wire logic                row_boundary_strobe_oe,
	input wire logic                int_n_o,
	input wire logic                int_n_oe
);
	import rsif_pkg::*;
	logic [3:0] ss_age;
	logic [3:0] next_ss_age;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Cycles since select was last low; the interrupt may only drop shortly after that.
	always_comb
	begin
		next_ss_age = ss_age;
		if (!ss_n)
			next_ss_age = 4'h0;
		else if (ss_age != 4'hF)
			next_ss_age = ss_age + 4'h1;
	end
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ss_age <= 4'hF;
		else
			ss_age <= next_ss_age;
	end
	sequence s_access;
		psel && $rose(penable);
	endsequence
	sequence s_sel_fall;
		$fell(ss_n) ##1 !ss_n;
	endsequence
	a_ready_after_one: assert property (s_access |=> pready)
		else $error("pready not one cycle into access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_paired: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_od_strobe: assert property (row_boundary_strobe_o == 1'b0)
		else $error("strobe pin driven high");
	a_od_int: assert property (int_n_o == 1'b0)
		else $error("interrupt pin driven high");
	a_int_clear: assert property (s_sel_fall |-> ##[0:5] !int_n_oe)
		else $error("interrupt not cleared by select");
	a_int_held: assert property ($fell(int_n_oe) |-> ss_age < 4'h6)
		else $error("interrupt released without select");
	a_int_cause: assert property ($rose(int_n_oe) |-> (end_marks != 8'h00
		|| row_addr == 12'h95F || $past(row_addr, 2) == 12'h95F))
		else $error("interrupt without full or marker");
	a_strobe_low_min: assert property ($rose(row_boundary_strobe_oe)
		|-> row_boundary_strobe_oe[*8])
		else $error("strobe low phase too short");
	a_strobe_high_min: assert property ($fell(row_boundary_strobe_oe)
		|=> !row_boundary_strobe_oe[*8])
		else $error("strobe high phase too short");
endmodule
bind rsif_top rsif_props #(.ROW_HIGH_TICKS(ROW_HIGH_TICKS), .ROW_LOW_TICKS(ROW_LOW_TICKS)) u_props
(
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .ss_n(ss_n), .end_marks(end_marks), .row_addr(row_addr),
	.row_boundary_strobe_o(row_boundary_strobe_o),
	.row_boundary_strobe_oe(row_boundary_strobe_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe)
);

// *** tb/rsif_host.sv ***
// Host model: select frames and the optional external sample clock.
`timescale 1ns/100ps
module rsif_host
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rst,
	// Requests from the bench.
	input  wire logic clr_req,
	input  wire logic ext_run,
	// Pins.
	output logic      ss_n,
	output logic      external_sample_clock
);
	logic       phase;
	logic [2:0] low_cnt;
	// Each frame is a short low pulse; only its falling edge matters to the block.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ss_n    <= 1'b1;
			low_cnt <= 3'h0;
		end
		else if (clr_req)
		begin
			ss_n    <= 1'b0;
			low_cnt <= 3'h4;
		end
		else if (low_cnt != 3'h0)
		begin
			low_cnt <= low_cnt - 3'h1;
			ss_n    <= (low_cnt == 3'h1);
		end
	end
	// The clock toggles every other cycle, far faster than real, to keep rows short.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			phase                 <= 1'b0;
			external_sample_clock <= 1'b0;
		end
		else
		begin
			phase <= ~phase;
			if (!ext_run)
				external_sample_clock <= 1'b0;
			else if (phase)
				external_sample_clock <= ~external_sample_clock;
		end
	end
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the row strobe block.
`timescale 1ns/100ps
`include "rsif_defines.svh"
module tb;
	import rsif_pkg::*;
	localparam int HI = 14;
	localparam int LO = 2;
	localparam int TK = 8; // Cycles per tick with the host clock halved inside the block.
	logic       clk_sys = 1'b0;
	logic       rst     = 1'b1;
	logic       psel    = 1'b0;
	logic       penable = 1'b0;
	logic       pwrite  = 1'b0;
	rsif_addr_t paddr   = 8'h00;
	rsif_word_t pwdata  = 32'h0;
	logic       clr_req = 1'b0;
	logic       ext_run = 1'b0;
	logic [7:0] marks   = 8'h00;
	rsif_word_t prdata, rd;
	rsif_row_t  row_addr;
	logic       pready, pslverr, ss_n, ext_clk, rs_o, rs_oe, in_o, in_oe, er;
	int         fail_count = 0;
	int         n_tests    = 0;
	int         seed       = 32'hA25C8761;
	int         t_hi, t_lo, n_rows;
	// Both pins have pull-ups, so a released line reads high.
	wire rs_pin  = rs_oe ? rs_o : 1'b1;
	wire int_pin = in_oe ? in_o : 1'b1;
	always #2 clk_sys = ~clk_sys;
	rsif_top #(.ROW_HIGH_TICKS(17'h0000E), .ROW_LOW_TICKS(17'h00002)) u_rsif_top
	(
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ss_n(ss_n), .external_sample_clock(ext_clk), .end_marks(marks), .row_addr(row_addr),
		.row_boundary_strobe_i(rs_pin), .row_boundary_strobe_o(rs_o),
		.row_boundary_strobe_oe(rs_oe), .int_n_i(int_pin), .int_n_o(in_o), .int_n_oe(in_oe)
	);
	rsif_host u_rsif_host
	(
		.clk_sys(clk_sys), .rst(rst), .clr_req(clr_req), .ext_run(ext_run), .ss_n(ss_n),
		.external_sample_clock(ext_clk)
	);
	function automatic int exp_hi(input logic rec, input logic cue);
		return ((cue ? 56 : HI) + (rec ? LO : 0)) * TK;
	endfunction
	function automatic rsif_word_t exp_int(input logic full, input logic mark);
		return {29'h0, 1'b1, mark, full};
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input rsif_word_t got, input rsif_word_t exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi, input string what);
		n_tests++;
		if (got < lo || got > hi)
		begin
			fail_count++;
			$display("ERROR %0t %s: %0d not in %0d..%0d", $time, what, got, lo, hi);
		end
	endtask
	// One APB transfer; the request holds until pready is seen at a rising edge.
	task automatic apb(input logic w, input rsif_addr_t a, input rsif_word_t d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		chk(n, 32'h00000002, "access cycles");
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Starts an operation and times the strobe until the interrupt or a cycle limit.
	task automatic run(input logic rec, cue, ext, input rsif_row_t row, input logic [7:0] m,
		input int limit);
		logic last;
		marks   <= m;
		ext_run <= ext;
		apb(1'b1, `RSIF_ROW_OFS, {20'h0, row});
		apb(1'b1, `RSIF_CTRL_OFS, {28'h0, ext, cue, rec, 1'b1});
		t_hi = 0;
		t_lo = 0;
		n_rows = 0;
		last = 1'b0;
		for (int n = 0; n < limit && in_oe !== 1'b1; n++)
		begin
			@(posedge clk_sys);
			if (rs_oe === 1'b1 && !last)
				n_rows++;
			if (n_rows == 0)
				t_hi++;
			else if (n_rows == 1 && rs_oe === 1'b1)
				t_lo++;
			last = rs_oe;
		end
	endtask
	// Reads the interrupt status, then clears it with a select frame.
	task automatic read_clear(input rsif_word_t exp);
		apb(1'b0, `RSIF_INTSTAT_OFS, 32'h0);
		chk(rd, exp, "interrupt status");
		chk(int_pin, 1'b0, "interrupt pin low");
		clr_req <= 1'b1;
		@(posedge clk_sys);
		clr_req <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chk(int_pin, 1'b1, "interrupt released");
		apb(1'b0, `RSIF_INTSTAT_OFS, 32'h0);
		chk(rd, 32'h0, "status cleared");
	endtask
	initial
	begin
		rsif_row_t r;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({rs_oe, in_oe}, 2'b00, "idle pins");
		apb(1'b0, 8'h10, 32'h0);
		chk(er, 1'b1, "unmapped address");
		// Internal tick source, marker in the first segment.
		run(1'b0, 1'b0, 1'b0, 12'h010, 8'h01, 3000);
		read_clear(exp_int(1'b0, 1'b1));
		// Every marker position, random start rows.
		for (int k = 0; k < 8; k++)
		begin
			r = 12'($random(seed)) & 12'h7FF;
			run(1'b0, 1'b0, 1'b1, r, 8'h01 << k, 400);
			if (k < 7)
				chk_rng(t_hi, (k + 1) * 2 * TK - 10, (k + 1) * 2 * TK + 10, "marker stop");
			else
				chk_rng(t_lo, LO * TK - 3, LO * TK + 3, "row low phase");
			chk_rng(t_hi, 0, exp_hi(1'b0, 1'b0) + 10, "row high phase");
			read_clear(exp_int(1'b0, 1'b1));
		end
		// Record over the last two rows: markers ignored, memory full.
		run(1'b1, 1'b0, 1'b1, 12'h95E, 8'hFF, 2000);
		chk_rng(t_hi, exp_hi(1'b1, 1'b0) - 10, exp_hi(1'b1, 1'b0) + 10, "record prime");
		chk_rng(n_rows, 2, 2, "rows recorded");
		read_clear(exp_int(1'b1, 1'b0));
		// Cueing playback of the last row.
		run(1'b0, 1'b1, 1'b1, 12'h95F, 8'h00, 2000);
		chk_rng(t_hi, exp_hi(1'b0, 1'b1) - 10, exp_hi(1'b0, 1'b1) + 10, "cue high");
		chk_rng(t_lo, 8 * TK - 3, 8 * TK + 3, "cue low");
		read_clear(exp_int(1'b1, 1'b0));
		// Software stop in the second row raises nothing and releases the strobe.
		r = 12'($random(seed)) & 12'h7FF;
		run(1'b0, 1'b0, 1'b1, r, 8'h00, 200);
		chk_rng(n_rows, 1, 1, "one row per period");
		chk(row_addr, r + 12'h001, "row advanced");
		apb(1'b1, `RSIF_CTRL_OFS, 32'h8);
		repeat (4) @(posedge clk_sys);
		chk({rs_oe, in_oe}, 2'b00, "stopped pins");
		apb(1'b0, `RSIF_STATUS_OFS, 32'h0);
		chk(rd[`RSIF_ST_ACTIVE], 1'b0, "operation stopped");
		apb(1'b0, `RSIF_INTSTAT_OFS, 32'h0);
		chk(rd, 32'h0, "no interrupt on stop");
		final_report();
	end
	initial
	begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule
